// ===== core_model.sv
`timescale 1ns/1ps

// Core side: services one exception class at a time
module core_model
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic nrst_i,
	// Requests from the controller
	input wire logic irq_i,
	input wire logic fiq_i,
	// Class in service: 0 none, 1 normal, 2 fast
	output logic [1:0] taken_o
);
	logic [1:0] next_taken;

	// Fast exception preempts a normal one
	always_comb
	begin
		next_taken = fiq_i ? 2'h2 : (irq_i ? 2'h1 : 2'h0);
	end

	// Register the class in service
	always_ff @(posedge clk_i)
	begin
		taken_o <= nrst_i ? next_taken : 2'h0;
	end
endmodule

// ===== irq_level_arbiter.sv
`timescale 1ns/1ps

module irq_level_arbiter
	import irq_nest_pkg::*;
(
	// Requests and levels
	input wire req_t req_i,
	input wire level_vec_t levels_i,
	// Nesting state
	input wire logic nest_en_i,
	input wire logic [7:0] in_service_i,
	// Selected source
	output arb_result_s result_o
);

	level_t floor_lvl;
	logic blocked;

	// Pick lowest level, then lowest source number; levels ignored without nesting
	always_comb
	begin
		result_o = '0;
		floor_lvl = lowest_set(in_service_i);
		blocked = 1'b0;
		for (int i = 0; i < 22; i++)
		begin
			blocked = nest_en_i && (in_service_i != 8'h00) && (levels_i[i] >= floor_lvl);
			if (req_i[i] && !blocked)
			begin
				if (!result_o.valid || (nest_en_i && levels_i[i] < result_o.level))
				begin
					result_o.valid = 1'b1;
					result_o.src = 5'(i);
					result_o.level = levels_i[i];
				end
			end
		end
	end

endmodule

// ===== irq_nest_consts.svh
`ifndef IRQ_NEST_CONSTS_SVH
`define IRQ_NEST_CONSTS_SVH

// Register byte addresses
`define ADDR_VEC_BASE 32'hffff0014
`define ADDR_NORMAL_VEC 32'hffff001c
`define ADDR_PRIO_A 32'hffff0020
`define ADDR_PRIO_B 32'hffff0024
`define ADDR_PRIO_C 32'hffff0028
`define ADDR_NEST_CTL 32'hffff0030
`define ADDR_NORMAL_ISR 32'hffff003c
`define ADDR_EVT_STATUS 32'hffff0080
`define ADDR_EVT_MASK 32'hffff0084
`define ADDR_FAST_VEC 32'hffff011c
`define ADDR_FAST_ISR 32'hffff013c

// Reset values
`define RST_PRIO 32'h00000000
`define RST_NEST 2'h0
`define RST_ISR 8'h00
`define RST_BASE 16'h0000
`define RST_EVT 3'h0

// Writable bits of the priority registers
`define MASK_PRIO_A 32'h77777770
`define MASK_PRIO_B 32'h77777777
`define MASK_PRIO_C 32'h00777777

// Nesting control bits
`define NEST_NORMAL_BIT 0
`define NEST_FAST_BIT 1

// Vector register fields
`define VEC_BASE_LSB 7
`define VEC_SRC_LSB 2

// Event status bits
`define EVT_NORMAL_CLAIM 0
`define EVT_FAST_CLAIM 1
`define EVT_RETIRE 2

// Level of source zero, which has no field
`define SRC0_LEVEL 3'h7

// Level field positions, first priority register
`define LSB_PLL_LOCK 28
`define LSB_ADC 24
`define LSB_FLASH_CTRL 20
`define LSB_TIMER2 16
`define LSB_TIMER1 12
`define LSB_TIMER0 8
`define LSB_SOFTWARE_INT 4
// Second priority register
`define LSB_SUPPLY_MON 28
`define LSB_COMPARATOR 24
`define LSB_EXT_INT0 20
`define LSB_SERIAL_PERIPH 16
`define LSB_TWOWIRE1_TARGET 12
`define LSB_TWOWIRE1_CTRL 8
`define LSB_TWOWIRE0_TARGET 4
`define LSB_TWOWIRE0_CTRL 0
// Third priority register
`define LSB_PULSE_WIDTH 20
`define LSB_LOGIC_ARRAY1 16
`define LSB_EXT_INT3 12
`define LSB_EXT_INT2 8
`define LSB_LOGIC_ARRAY0 4
`define LSB_EXT_INT1 0

// Bus responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ===== irq_nest_pkg.sv
package irq_nest_pkg;

	typedef logic [2:0] level_t;
	typedef logic [4:0] src_t;
	typedef logic [21:0] req_t;
	typedef level_t [21:0] level_vec_t;

	// Arbitration result of one class
	typedef struct packed
	{
		logic valid;
		src_t src;
		level_t level;
	} arb_result_s;

	// Write channel collection state
	typedef enum logic {WR_COLLECT, WR_RESP} wr_state_e;

	// Index of the lowest set in-service bit (highest priority level)
	function automatic level_t lowest_set(input logic [7:0] bits);
		level_t idx;
		idx = 3'h0;
		for (int i = 7; i >= 0; i--)
		begin
			if (bits[i])
				idx = 3'(i);
		end
		return idx;
	endfunction

endpackage

// ===== irq_priority_nesting_ctrl.sv
`timescale 1ns/1ps
`include "irq_nest_consts.svh"


module irq_priority_nesting_ctrl
	import irq_nest_pkg::*;
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic nrst_i,
	// AXI4-Lite write channels
	input wire logic [31:0] s_axi_awaddr_i,
	input wire logic s_axi_awvalid_i,
	output logic s_axi_awready_o,
	input wire logic [31:0] s_axi_wdata_i,
	input wire logic [3:0] s_axi_wstrb_i,
	input wire logic s_axi_wvalid_i,
	output logic s_axi_wready_o,
	output logic [1:0] s_axi_bresp_o,
	output logic s_axi_bvalid_o,
	input wire logic s_axi_bready_i,
	// AXI4-Lite read channels
	input wire logic [31:0] s_axi_araddr_i,
	input wire logic s_axi_arvalid_i,
	output logic s_axi_arready_o,
	output logic [31:0] s_axi_rdata_o,
	output logic [1:0] s_axi_rresp_o,
	output logic s_axi_rvalid_o,
	input wire logic s_axi_rready_i,
	// Enabled pending requests from peripherals
	input wire req_t normal_req_i,
	input wire req_t fast_req_i,
	// Requests to the core and event interrupt
	output logic irq_o,
	output logic fiq_o,
	output logic evt_int_o
);

	// ----------------------------------------------------------------
	// Functions
	// ----------------------------------------------------------------

	// Merge write data into a register under the byte strobes
	function automatic logic [31:0] merge_strb(input logic [31:0] old, input logic [31:0] val,
		input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int b = 0; b < 4; b++)
		begin
			if (strb[b])
				res[b*8 +: 8] = val[b*8 +: 8];
		end
		return res;
	endfunction

	// Spread the three priority registers into one level per source
	function automatic level_vec_t map_levels(input logic [31:0] a, input logic [31:0] b,
		input logic [31:0] c);
		level_vec_t v;
		v[0] = `SRC0_LEVEL;
		v[1] = a[`LSB_SOFTWARE_INT +: 3];
		v[2] = a[`LSB_TIMER0 +: 3];
		v[3] = a[`LSB_TIMER1 +: 3];
		v[4] = a[`LSB_TIMER2 +: 3];
		v[5] = a[`LSB_FLASH_CTRL +: 3];
		v[6] = a[`LSB_ADC +: 3];
		v[7] = a[`LSB_PLL_LOCK +: 3];
		v[8] = b[`LSB_TWOWIRE0_TARGET +: 3];
		v[9] = b[`LSB_TWOWIRE0_CTRL +: 3];
		v[10] = b[`LSB_TWOWIRE1_CTRL +: 3];
		v[11] = b[`LSB_TWOWIRE1_TARGET +: 3];
		v[12] = b[`LSB_SERIAL_PERIPH +: 3];
		v[13] = b[`LSB_EXT_INT0 +: 3];
		v[14] = b[`LSB_COMPARATOR +: 3];
		v[15] = b[`LSB_SUPPLY_MON +: 3];
		v[16] = c[`LSB_LOGIC_ARRAY0 +: 3];
		v[17] = c[`LSB_EXT_INT1 +: 3];
		v[18] = c[`LSB_EXT_INT2 +: 3];
		v[19] = c[`LSB_EXT_INT3 +: 3];
		v[20] = c[`LSB_LOGIC_ARRAY1 +: 3];
		v[21] = c[`LSB_PULSE_WIDTH +: 3];
		return v;
	endfunction

	// Vector word: base and selected source number
	function automatic logic [31:0] vector_word(input logic [15:0] base, input arb_result_s r);
		logic [31:0] w;
		w = 32'h00000000;
		w[`VEC_BASE_LSB +: 16] = base;
		w[`VEC_SRC_LSB +: 5] = r.src;
		return w;
	endfunction

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------

	logic [31:0] prio_a, prio_b, prio_c, next_prio_a, next_prio_b, next_prio_c;
	logic [1:0] nest_ctl, next_nest_ctl;
	logic [15:0] vec_base, next_vec_base;
	logic [7:0] normal_isr, fast_isr, next_normal_isr, next_fast_isr;
	logic [2:0] evt_status, evt_mask, next_evt_status, next_evt_mask;
	wr_state_e wr_state, next_wr_state;
	logic aw_held, w_held, next_aw_held, next_w_held;
	logic [31:0] awaddr_q, wdata_q, next_awaddr_q, next_wdata_q;
	logic [3:0] wstrb_q, next_wstrb_q;
	logic next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
	logic [1:0] next_bresp, next_rresp;
	logic [31:0] next_rdata, rd_value, base_merged;
	logic rd_hit, wr_fire, rd_fire, next_irq, next_fiq;
	logic normal_claim, fast_claim, normal_retire, fast_retire;
	level_vec_t levels;
	arb_result_s normal_res, fast_res;

	// ----------------------------------------------------------------
	// Arbitration
	// ----------------------------------------------------------------

	assign levels = map_levels(prio_a, prio_b, prio_c);

	irq_level_arbiter u_normal_arb (
		.req_i(normal_req_i),
		.levels_i(levels),
		.nest_en_i(nest_ctl[`NEST_NORMAL_BIT]),
		.in_service_i(normal_isr),
		.result_o(normal_res)
	);

	irq_level_arbiter u_fast_arb (
		.req_i(fast_req_i),
		.levels_i(levels),
		.nest_en_i(nest_ctl[`NEST_FAST_BIT]),
		.in_service_i(fast_isr),
		.result_o(fast_res)
	);

	// ----------------------------------------------------------------
	// Bus handshakes
	// ----------------------------------------------------------------

	assign wr_fire = (wr_state == WR_COLLECT) && aw_held && w_held;
	assign rd_fire = s_axi_arvalid_i && s_axi_arready_o;

	// Collect address and data in either order, then answer
	always_comb
	begin
		next_wr_state = wr_state;
		next_aw_held = aw_held;
		next_w_held = w_held;
		next_awaddr_q = awaddr_q;
		next_wdata_q = wdata_q;
		next_wstrb_q = wstrb_q;
		next_bvalid = s_axi_bvalid_o;
		next_bresp = s_axi_bresp_o;
		case (wr_state)
			WR_COLLECT:
			begin
				if (s_axi_awvalid_i && s_axi_awready_o)
				begin
					next_aw_held = 1'b1;
					next_awaddr_q = s_axi_awaddr_i;
				end
				if (s_axi_wvalid_i && s_axi_wready_o)
				begin
					next_w_held = 1'b1;
					next_wdata_q = s_axi_wdata_i;
					next_wstrb_q = s_axi_wstrb_i;
				end
				if (wr_fire)
				begin
					next_wr_state = WR_RESP;
					next_bvalid = 1'b1;
					next_bresp = (awaddr_q == `ADDR_NORMAL_VEC || awaddr_q == `ADDR_FAST_VEC ||
						!rd_hit_addr(awaddr_q)) ? `RESP_SLVERR : `RESP_OKAY;
				end
			end
			WR_RESP:
			begin
				if (s_axi_bready_i)
				begin
					next_wr_state = WR_COLLECT;
					next_bvalid = 1'b0;
					next_aw_held = 1'b0;
					next_w_held = 1'b0;
				end
			end
			default:
				next_wr_state = WR_COLLECT;
		endcase
		next_awready = (next_wr_state == WR_COLLECT) && !next_aw_held;
		next_wready = (next_wr_state == WR_COLLECT) && !next_w_held;
		next_rvalid = s_axi_rvalid_o;
		next_rdata = s_axi_rdata_o;
		next_rresp = s_axi_rresp_o;
		if (rd_fire)
		begin
			next_rvalid = 1'b1;
			next_rdata = rd_value;
			next_rresp = rd_hit ? `RESP_OKAY : `RESP_SLVERR;
		end
		else if (s_axi_rvalid_o && s_axi_rready_i)
			next_rvalid = 1'b0;
		next_arready = !next_rvalid;
	end

	// Address decode shared by both channels
	function automatic logic rd_hit_addr(input logic [31:0] addr);
		return addr == `ADDR_VEC_BASE || addr == `ADDR_NORMAL_VEC || addr == `ADDR_PRIO_A ||
			addr == `ADDR_PRIO_B || addr == `ADDR_PRIO_C || addr == `ADDR_NEST_CTL ||
			addr == `ADDR_NORMAL_ISR || addr == `ADDR_EVT_STATUS ||
			addr == `ADDR_EVT_MASK || addr == `ADDR_FAST_VEC || addr == `ADDR_FAST_ISR;
	endfunction

	// Read multiplexer; reserved bits return zero
	always_comb
	begin
		rd_hit = rd_hit_addr(s_axi_araddr_i);
		case (s_axi_araddr_i)
			`ADDR_VEC_BASE: rd_value = {16'h0000, vec_base};
			`ADDR_NORMAL_VEC: rd_value = vector_word(vec_base, normal_res);
			`ADDR_FAST_VEC: rd_value = vector_word(vec_base, fast_res);
			`ADDR_PRIO_A: rd_value = prio_a;
			`ADDR_PRIO_B: rd_value = prio_b;
			`ADDR_PRIO_C: rd_value = prio_c;
			`ADDR_NEST_CTL: rd_value = {30'h00000000, nest_ctl};
			`ADDR_NORMAL_ISR: rd_value = {24'h000000, normal_isr};
			`ADDR_FAST_ISR: rd_value = {24'h000000, fast_isr};
			`ADDR_EVT_STATUS: rd_value = {29'h00000000, evt_status};
			`ADDR_EVT_MASK: rd_value = {29'h00000000, evt_mask};
			default: rd_value = 32'h00000000;
		endcase
	end

	// ----------------------------------------------------------------
	// Registers and nesting state
	// ----------------------------------------------------------------

	// Claims on vector reads, retirement on in-service writes
	always_comb
	begin
		next_prio_a = prio_a;
		next_prio_b = prio_b;
		next_prio_c = prio_c;
		next_nest_ctl = nest_ctl;
		next_vec_base = vec_base;
		next_evt_mask = evt_mask;
		next_normal_isr = normal_isr;
		next_fast_isr = fast_isr;
		normal_retire = 1'b0;
		fast_retire = 1'b0;
		base_merged = merge_strb({16'h0000, vec_base}, wdata_q, wstrb_q);
		if (wr_fire)
		begin
			case (awaddr_q)
				`ADDR_PRIO_A: next_prio_a = merge_strb(prio_a, wdata_q, wstrb_q) & `MASK_PRIO_A;
				`ADDR_PRIO_B: next_prio_b = merge_strb(prio_b, wdata_q, wstrb_q) & `MASK_PRIO_B;
				`ADDR_PRIO_C: next_prio_c = merge_strb(prio_c, wdata_q, wstrb_q) & `MASK_PRIO_C;
				`ADDR_NEST_CTL: if (wstrb_q[0]) next_nest_ctl = wdata_q[1:0];
				`ADDR_VEC_BASE: next_vec_base = base_merged[15:0];
				`ADDR_EVT_MASK: if (wstrb_q[0]) next_evt_mask = wdata_q[2:0];
				`ADDR_NORMAL_ISR:
				begin
					// Only the highest-priority set level can go, one per write
					if (wstrb_q[0] && normal_isr != 8'h00 && wdata_q[lowest_set(normal_isr)])
					begin
						next_normal_isr[lowest_set(normal_isr)] = 1'b0;
						normal_retire = 1'b1;
					end
				end
				`ADDR_FAST_ISR:
				begin
					if (wstrb_q[0] && fast_isr != 8'h00 && wdata_q[lowest_set(fast_isr)])
					begin
						next_fast_isr[lowest_set(fast_isr)] = 1'b0;
						fast_retire = 1'b1;
					end
				end
				default: next_evt_mask = evt_mask;
			endcase
		end
		normal_claim = rd_fire && s_axi_araddr_i == `ADDR_NORMAL_VEC &&
			nest_ctl[`NEST_NORMAL_BIT] && normal_res.valid;
		fast_claim = rd_fire && s_axi_araddr_i == `ADDR_FAST_VEC &&
			nest_ctl[`NEST_FAST_BIT] && fast_res.valid;
		if (normal_claim)
			next_normal_isr[normal_res.level] = 1'b1;
		if (fast_claim)
			next_fast_isr[fast_res.level] = 1'b1;
		// Read clears status, but a fresh event in the same cycle wins
		next_evt_status = evt_status;
		if (rd_fire && s_axi_araddr_i == `ADDR_EVT_STATUS)
			next_evt_status = `RST_EVT;
		next_evt_status[`EVT_NORMAL_CLAIM] = next_evt_status[`EVT_NORMAL_CLAIM] | normal_claim;
		next_evt_status[`EVT_FAST_CLAIM] = next_evt_status[`EVT_FAST_CLAIM] | fast_claim;
		next_evt_status[`EVT_RETIRE] = next_evt_status[`EVT_RETIRE] | normal_retire | fast_retire;
		// Levels ignored and no nesting when both bits clear; fast always first
		next_fiq = fast_res.valid;
		next_irq = normal_res.valid && !fast_res.valid;
	end

	// Register every group; synchronous active-low reset
	always_ff @(posedge clk_i)
	begin
		if (!nrst_i)
		begin
			prio_a <= `RST_PRIO;
			prio_b <= `RST_PRIO;
			prio_c <= `RST_PRIO;
			nest_ctl <= `RST_NEST;
			vec_base <= `RST_BASE;
			normal_isr <= `RST_ISR;
			fast_isr <= `RST_ISR;
			evt_status <= `RST_EVT;
			evt_mask <= `RST_EVT;
			wr_state <= WR_COLLECT;
			aw_held <= 1'b0;
			w_held <= 1'b0;
			awaddr_q <= 32'h00000000;
			wdata_q <= 32'h00000000;
			wstrb_q <= 4'h0;
			s_axi_awready_o <= 1'b0;
			s_axi_wready_o <= 1'b0;
			s_axi_bvalid_o <= 1'b0;
			s_axi_bresp_o <= `RESP_OKAY;
			s_axi_arready_o <= 1'b0;
			s_axi_rvalid_o <= 1'b0;
			s_axi_rdata_o <= 32'h00000000;
			s_axi_rresp_o <= `RESP_OKAY;
			irq_o <= 1'b0;
			fiq_o <= 1'b0;
			evt_int_o <= 1'b0;
		end
		else
		begin
			prio_a <= next_prio_a;
			prio_b <= next_prio_b;
			prio_c <= next_prio_c;
			nest_ctl <= next_nest_ctl;
			vec_base <= next_vec_base;
			normal_isr <= next_normal_isr;
			fast_isr <= next_fast_isr;
			evt_status <= next_evt_status;
			evt_mask <= next_evt_mask;
			wr_state <= next_wr_state;
			aw_held <= next_aw_held;
			w_held <= next_w_held;
			awaddr_q <= next_awaddr_q;
			wdata_q <= next_wdata_q;
			wstrb_q <= next_wstrb_q;
			s_axi_awready_o <= next_awready;
			s_axi_wready_o <= next_wready;
			s_axi_bvalid_o <= next_bvalid;
			s_axi_bresp_o <= next_bresp;
			s_axi_arready_o <= next_arready;
			s_axi_rvalid_o <= next_rvalid;
			s_axi_rdata_o <= next_rdata;
			s_axi_rresp_o <= next_rresp;
			irq_o <= next_irq;
			fiq_o <= next_fiq;
			evt_int_o <= |(next_evt_status & next_evt_mask);
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!nrst_i);

	a_prio_a_store: assert property ((wr_fire && awaddr_q == `ADDR_PRIO_A &&
		wstrb_q == 4'hf) |=> prio_a == ($past(wdata_q) & `MASK_PRIO_A))
		else $error("priority a store wrong");
	a_src0_unfielded: assert property (prio_a[3:0] == 4'h0 && levels[0] == `SRC0_LEVEL)
		else $error("source zero gained a field");
	a_prio_b_store: assert property ((wr_fire && awaddr_q == `ADDR_PRIO_B &&
		wstrb_q == 4'hf) |=> prio_b == ($past(wdata_q) & `MASK_PRIO_B))
		else $error("priority b store wrong");
	a_prio_b_fields: assert property (levels[9] == prio_b[2:0] &&
		levels[12] == prio_b[18:16]) else $error("priority b field map wrong");
	a_prio_c_store: assert property ((wr_fire && awaddr_q == `ADDR_PRIO_C &&
		wstrb_q == 4'hf) |=> prio_c[31:23] == 9'h000 &&
		prio_c[22:0] == ($past(wdata_q[22:0]) & 23'h777777))
		else $error("priority c store wrong");
	a_fast_no_nest: assert property ((!nest_ctl[`NEST_FAST_BIT] && rd_fire &&
		s_axi_araddr_i == `ADDR_FAST_VEC) |=> (fast_isr & ~$past(fast_isr)) == 8'h00)
		else $error("fast level claimed without nesting");
	a_normal_no_nest: assert property ((!nest_ctl[`NEST_NORMAL_BIT] && rd_fire &&
		s_axi_araddr_i == `ADDR_NORMAL_VEC) |=> (normal_isr & ~$past(normal_isr)) == 8'h00)
		else $error("normal level claimed without nesting");
	a_plain_delivery: assert property ((nest_ctl == 2'h0 && normal_req_i != 22'h0)
		|-> normal_res.valid && normal_req_i[normal_res.src]) else $error("request dropped");
	a_fast_first: assert property (fast_res.valid |=> fiq_o && !irq_o)
		else $error("fast did not take precedence");
	a_claim_sets: assert property (normal_claim |=> normal_isr[$past(normal_res.level)])
		else $error("in-service bit not set on claim");
	a_level_block: assert property ((nest_ctl[`NEST_NORMAL_BIT] && normal_isr != 8'h00 &&
		normal_res.valid) |-> normal_res.level < lowest_set(normal_isr))
		else $error("blocked level won");
	a_retire_one: assert property ((wr_fire && awaddr_q == `ADDR_NORMAL_ISR &&
		wdata_q[7:0] == 8'hff && wstrb_q[0] && normal_isr != 8'h00 && !normal_claim) ##1
		(normal_isr == 8'h00 || $past(normal_isr) != 8'h00) |->
		normal_isr == ($past(normal_isr) & ($past(normal_isr) - 8'h01)))
		else $error("retire did not clear one level");
	a_vector_shape: assert property ((rd_fire && s_axi_araddr_i == `ADDR_NORMAL_VEC)
		|=> s_axi_rdata_o[31:23] == 9'h000 && s_axi_rdata_o[1:0] == 2'h0 &&
		s_axi_rdata_o[6:2] == $past(normal_res.src)) else $error("vector word malformed");
	a_fast_claim: assert property (fast_claim |=> fast_isr[$past(fast_res.level)])
		else $error("fast in-service bit not set");
	a_lowest_wins: assert property ((nest_ctl[`NEST_NORMAL_BIT] && normal_res.valid &&
		normal_isr == 8'h00 && normal_req_i[1]) |-> normal_res.level <= levels[1])
		else $error("higher level chosen");
	a_reserved_zero: assert property ((rd_fire && s_axi_araddr_i == `ADDR_NORMAL_ISR)
		|=> s_axi_rdata_o[31:8] == 24'h000000) else $error("reserved bits not zero");

	c_normal_claim: cover property (normal_claim ##[1:20] normal_retire);
	c_fast_over_normal: cover property (normal_res.valid && fast_res.valid ##1 fiq_o);
	c_nested_two: cover property (normal_claim ##[1:50] normal_claim);

endmodule

// ===== tb_irq_priority_nesting_ctrl.sv
`timescale 1ns/1ps
`include "irq_nest_consts.svh"
`define CHK(a, b) \
	begin \
		total_checks++; \
		if ((a) !== (b)) \
		begin \
			miscompares++; \
			$display("unexpected at %0t: %h not %h", $time, a, b); \
		end \
	end

module tb_irq_priority_nesting_ctrl
	import irq_nest_pkg::*;
;
	logic clk_i, nrst_i, awv, wv, arv, awr, wr_o, bv, arr, rv, irq, fiq, evt;
	logic [31:0] awa, wd, ara, rdat, d;
	logic [1:0] br, rr, r, taken, nest;
	logic [2:0] st;
	logic [3:0] ws;
	req_t nreq, freq, nq, fq;
	int miscompares, total_checks, seed, s;
	logic [31:0] prio [3];
	logic [7:0] isr [2];
	logic [15:0] base;
	int lsb [22] = '{0, 4, 8, 12, 16, 20, 24, 28, 4, 0, 8, 12, 16, 20, 24, 28, 4, 0, 8, 12, 16, 20};
	logic [31:0] pa [3] = '{`ADDR_PRIO_A, `ADDR_PRIO_B, `ADDR_PRIO_C};
	logic [31:0] pm [3] = '{`MASK_PRIO_A, `MASK_PRIO_B, `MASK_PRIO_C};
	logic [31:0] ia [2] = '{`ADDR_NORMAL_ISR, `ADDR_FAST_ISR};

	irq_priority_nesting_ctrl irq_priority_nesting_ctrl_inst (.clk_i(clk_i), .nrst_i(nrst_i),
		.s_axi_awaddr_i(awa), .s_axi_awvalid_i(awv), .s_axi_awready_o(awr),
		.s_axi_wdata_i(wd), .s_axi_wstrb_i(ws), .s_axi_wvalid_i(wv), .s_axi_wready_o(wr_o),
		.s_axi_bresp_o(br), .s_axi_bvalid_o(bv), .s_axi_bready_i(1'b1),
		.s_axi_araddr_i(ara), .s_axi_arvalid_i(arv), .s_axi_arready_o(arr),
		.s_axi_rdata_o(rdat), .s_axi_rresp_o(rr), .s_axi_rvalid_o(rv), .s_axi_rready_i(1'b1),
		.normal_req_i(nreq), .fast_req_i(freq), .irq_o(irq), .fiq_o(fiq), .evt_int_o(evt));

	core_model core_model_inst (.clk_i(clk_i), .nrst_i(nrst_i), .irq_i(irq), .fiq_i(fiq),
		.taken_o(taken));

	// Model: level of a source, source zero fixed lowest
	function automatic int lv(input int n);
		return (n == 0) ? 7 : (prio[n < 8 ? 0 : (n < 16 ? 1 : 2)] >> lsb[n]) & 7;
	endfunction

	// Model: selected source of class k, -1 when none
	function automatic int pick(input int k, input req_t q);
		int best;
		int bl;
		int lim;
		best = -1;
		bl = 8;
		lim = 8;
		for (int i = 7; i >= 0; i--)
			if (nest[k] && isr[k][i])
				lim = i;
		for (int n = 0; n < 22; n++)
			if (q[n] && best < 0 && !nest[k])
				best = n;
			else if (q[n] && nest[k] && lv(n) < lim && lv(n) < bl)
			begin
				best = n;
				bl = lv(n);
			end
		return best;
	endfunction

	// Bus write, waits for the response
	task automatic wrt(input logic [31:0] a, input logic [31:0] dv);
		logic ah;
		logic wh;
		logic bh;
		awa <= a;
		wd <= dv;
		awv <= 1'b1;
		wv <= 1'b1;
		bh = 1'b0;
		while (!bh)
		begin
			@(negedge clk_i);
			ah = awv && awr;
			wh = wv && wr_o;
			bh = bv === 1'b1;
			r = br;
			@(posedge clk_i);
			if (ah)
				awv <= 1'b0;
			if (wh)
				wv <= 1'b0;
		end
	endtask

	// Bus read, waits for the data
	task automatic rd(input logic [31:0] a);
		logic ah;
		logic rh;
		ara <= a;
		arv <= 1'b1;
		rh = 1'b0;
		while (!rh)
		begin
			@(negedge clk_i);
			ah = arv && arr;
			rh = rv === 1'b1;
			d = rdat;
			r = rr;
			@(posedge clk_i);
			if (ah)
				arv <= 1'b0;
		end
	endtask

	// Verdict and end of run
	task end_of_test();
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// Clock
	initial
	begin
		clk_i = 1'b0;
		forever #25 clk_i = ~clk_i;
	end

	// Watchdog against a hung handshake
	initial
	begin
		#1000000;
		miscompares++;
		end_of_test();
	end

	// Main sequence
	initial
	begin
		{nrst_i, awv, wv, arv, awa, wd, ara, nreq, freq} = '0;
		{miscompares, total_checks} = '0;
		ws = 4'hf;
		seed = 44;
		repeat (12) @(posedge clk_i);
		nrst_i <= 1'b1;
		@(posedge clk_i);
		for (int i = 0; i < 5; i++)
		begin
			rd(i < 3 ? pa[i] : (i == 3 ? `ADDR_NEST_CTL : `ADDR_NORMAL_ISR));
			`CHK(d, `RST_PRIO)
		end
		rd(32'hffff0040);
		`CHK({r, d}, {`RESP_SLVERR, 32'h0})
		wrt(`ADDR_NORMAL_VEC, 32'h1);
		`CHK(r, `RESP_SLVERR)
		wrt(`ADDR_EVT_MASK, 32'h3);
		base = 16'($random(seed));
		wrt(`ADDR_VEC_BASE, {16'h0, base});
		rd(`ADDR_EVT_STATUS);
		// Byte lane 1 only: the other lanes keep their reset value
		ws <= 4'h2;
		wrt(`ADDR_PRIO_B, 32'hffffffff);
		`CHK(r, `RESP_OKAY)
		ws <= 4'hf;
		rd(`ADDR_PRIO_B);
		`CHK(d, 32'h00007700)
		$display("reset and bus test done");
		{prio[0], prio[1], prio[2], isr[0], isr[1], st} = '0;
		for (int it = 0; it < 32; it++)
		begin
			for (int i = 0; i < 3 && it % 4 == 0; i++)
			begin
				d = $random(seed);
				prio[i] = d & pm[i];
				wrt(pa[i], d);
				rd(pa[i]);
				`CHK(d, prio[i])
			end
			nest = 2'(it);
			// Reserved control bits stay zero
			wrt(`ADDR_NEST_CTL, {30'h0, nest});
			rd(`ADDR_NEST_CTL);
			`CHK(d, {30'h0, nest})
			nq = req_t'($random(seed));
			fq = req_t'($random(seed) & $random(seed) & $random(seed));
			nreq <= nq;
			freq <= fq;
			repeat (3) @(posedge clk_i);
			@(negedge clk_i);
			`CHK(fiq, pick(1, fq) >= 0)
			`CHK(irq, pick(0, nq) >= 0 && pick(1, fq) < 0)
			`CHK(taken, {pick(1, fq) >= 0, pick(1, fq) < 0 && pick(0, nq) >= 0})
			@(posedge clk_i);
			for (int c = 0; c < 2; c++)
			begin
				rd(c ? `ADDR_FAST_VEC : `ADDR_NORMAL_VEC);
				s = pick(c, c ? fq : nq);
				if (s >= 0)
					`CHK(d, {9'h0, base, 5'(s), 2'h0})
				if (s >= 0 && nest[c])
				begin
					isr[c][lv(s)] = 1'b1;
					st[c] = 1'b1;
				end
			end
			repeat (2) @(posedge clk_i);
			@(negedge clk_i);
			`CHK(evt, |st[1:0])
			@(posedge clk_i);
			rd(`ADDR_EVT_STATUS);
			`CHK(d[2:0], st)
			st = 3'h0;
			for (int c = 0; c < 2; c++)
			begin
				rd(ia[c]);
				`CHK(d, {24'h0, isr[c]})
				if ($random(seed) & 1)
				begin
					wrt(ia[c], 32'hff);
					st[2] = st[2] | (isr[c] != 8'h0);
					isr[c] = isr[c] & (isr[c] - 8'h1);
				end
			end
		end
		$display("nesting test done");
		end_of_test();
	end
endmodule
